/* File: hw/flash_iap_pkg.sv */
package flash_iap_pkg;

  // register offsets on the byte-wide register port
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CLEAR = 8'h01;
  localparam logic [7:0] REG_ADDR_LO = 8'h02;
  localparam logic [7:0] REG_ADDR_HI = 8'h03;
  localparam logic [7:0] REG_D0_LO = 8'h04;
  localparam logic [7:0] REG_D0_HI = 8'h05;
  localparam logic [7:0] REG_D1_LO = 8'h06;
  localparam logic [7:0] REG_D1_HI = 8'h07;
  localparam logic [7:0] REG_D2_LO = 8'h08;
  localparam logic [7:0] REG_D2_HI = 8'h09;
  localparam logic [7:0] REG_D3_LO = 8'h0A;
  localparam logic [7:0] REG_D3_HI = 8'h0B;

  // control register field positions
  localparam int BIT_ENABLED = 7;
  localparam int MODE_HI = 6;
  localparam int MODE_LO = 4;
  localparam int BIT_UNLOCK = 3;
  localparam int BIT_WRITE = 2;
  localparam int BIT_READ_EN = 1;
  localparam int BIT_READ = 0;
  localparam int BIT_CLEAR = 0;

  // operation mode codes
  localparam logic [2:0] MODE_WRITE = 3'h0;
  localparam logic [2:0] MODE_ERASE = 3'h1;
  localparam logic [2:0] MODE_READ = 3'h3;
  localparam logic [2:0] MODE_UNLOCK = 3'h6;
  localparam logic [2:0] MODE_RESET = 3'h0;

  // geometry: 32 words per page, 13-bit word address
  localparam int PAGE_WORDS = 32;
  localparam int PTR_W = 5;
  localparam int ADDR_W = 13;
  localparam int WORD_W = 16;
  localparam logic [4:0] ADDR_HI_MASK = 5'h1F;
  localparam logic [PTR_W-1:0] PTR_LAST = 5'h1F;

  // unlock key, in register order low1..low3 then high1..high3
  localparam logic [7:0] KEY_L1 = 8'h00;
  localparam logic [7:0] KEY_L2 = 8'h0D;
  localparam logic [7:0] KEY_L3 = 8'hC3;
  localparam logic [7:0] KEY_H1 = 8'h04;
  localparam logic [7:0] KEY_H2 = 8'h09;
  localparam logic [7:0] KEY_H3 = 8'h40;

  // timing at 100 MHz
  localparam int CLK_PERIOD_NS = 10;
  localparam int OP_TIME_NS = 2200000;
  localparam int OP_CYCLES = OP_TIME_NS / CLK_PERIOD_NS;
  localparam int INSTR_CYCLE_NS = 40;
  localparam int READ_INSTR_CYCLES = 3;
  localparam int READ_CYCLES = (READ_INSTR_CYCLES * INSTR_CYCLE_NS) / CLK_PERIOD_NS;
  localparam int UNLOCK_TIME_NS = 10000;
  localparam int UNLOCK_CYCLES = UNLOCK_TIME_NS / CLK_PERIOD_NS;
  localparam int CNT_W = 18;
  localparam int UNLOCK_CNT_W = 10;

endpackage

/* File: hw/page_write_buffer.sv */
`timescale 1ns/1ns
`default_nettype none
module page_write_buffer (
  input wire logic clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [flash_iap_pkg::PTR_W-1:0] wr_idx,
  input wire logic [flash_iap_pkg::WORD_W-1:0] wr_data,
  input wire logic clr,
  input wire logic [flash_iap_pkg::PTR_W-1:0] rd_idx,
  output logic [flash_iap_pkg::WORD_W-1:0] rd_data
);
  import flash_iap_pkg::*;

  // one page of staged words
  logic [WORD_W-1:0] mem_q [PAGE_WORDS];

  // clear zeroes the whole page in one cycle; zero words program harmlessly
  always_ff @(posedge clk) begin
    if (rst || clr) begin
      for (int i = 0; i < PAGE_WORDS; i++) begin
        mem_q[i] <= '0;
      end
    end else if (wr_en) begin
      mem_q[wr_idx] <= wr_data;
    end
  end

  // combinational read feeds the programming walk
  assign rd_data = mem_q[rd_idx];

endmodule
`default_nettype wire

/* File: hw/unlock_checker.sv */
`timescale 1ns/1ns
`default_nettype none
module unlock_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [7:0] key_l1,
  input wire logic [7:0] key_l2,
  input wire logic [7:0] key_l3,
  input wire logic [7:0] key_h1,
  input wire logic [7:0] key_h2,
  input wire logic [7:0] key_h3,
  output logic active,
  output logic success
);
  import flash_iap_pkg::*;

  logic active_q; // procedure window open
  logic done_q; // key already accepted in this window
  logic [UNLOCK_CNT_W-1:0] cnt_q; // cycles spent in window
  logic key_ok;

  assign key_ok = (key_l1 == KEY_L1) && (key_l2 == KEY_L2) && (key_l3 == KEY_L3) &&
                  (key_h1 == KEY_H1) && (key_h2 == KEY_H2) && (key_h3 == KEY_H3);

  // window timer; drops the trigger on timeout whatever the key
  always_ff @(posedge clk) begin
    if (rst) begin
      active_q <= 1'b0;
      cnt_q <= '0;
    end else if (start) begin
      active_q <= 1'b1;
      cnt_q <= '0;
    end else if (active_q) begin
      cnt_q <= cnt_q + 1'b1;
      if (cnt_q == UNLOCK_CNT_W'(UNLOCK_CYCLES - 1)) begin
        active_q <= 1'b0;
      end
    end
  end

  // a key matching inside the window grants once
  always_ff @(posedge clk) begin
    if (rst || start) begin
      done_q <= 1'b0;
    end else if (active_q && key_ok) begin
      done_q <= 1'b1;
    end
  end

  assign active = active_q;
  assign success = active_q && key_ok && !done_q;

endmodule
`default_nettype wire

/* File: hw/flash_iap_page_programmer.sv */
// The strobed register port and the address map were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module flash_iap_page_programmer #(
  parameter int OP_CYCLES_P = flash_iap_pkg::OP_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic cpu_stall,
  output logic [flash_iap_pkg::ADDR_W-1:0] flash_addr,
  output logic [flash_iap_pkg::WORD_W-1:0] flash_wdata,
  output logic flash_prog,
  output logic flash_erase,
  output logic flash_rd,
  input wire logic [flash_iap_pkg::WORD_W-1:0] flash_rdata
);
  import flash_iap_pkg::*;

  // idle, then one state per job phase; any state but idle stalls the cpu
  typedef enum logic [2:0] {ST_IDLE, ST_ERASE, ST_PROG, ST_WAIT, ST_READ} op_state_e;

  op_state_e state_q; // sequencer state
  logic enabled_q; // erase/write enabled flag
  logic [2:0] mode_q; // operation mode field
  logic read_en_q; // read enable bit
  logic clear_q; // buffer clear trigger
  logic [7:0] addr_lo_q; // flash address low byte
  logic [4:0] addr_hi_q; // flash address high bits
  logic [7:0] d0_lo_q, d0_hi_q; // data pair 0
  logic [7:0] d1_lo_q, d1_hi_q, d2_lo_q, d2_hi_q, d3_lo_q, d3_hi_q; // key pairs
  logic [PTR_W-1:0] ptr_q; // write buffer pointer
  logic [PTR_W-1:0] walk_q; // word index during programming
  logic [CNT_W-1:0] cnt_q; // cycles since operation start
  logic [7:0] rdata_q; // read data register
  logic [ADDR_W-1:0] flash_addr_q;
  logic [WORD_W-1:0] flash_wdata_q;
  logic flash_prog_q, flash_erase_q, flash_rd_q;

  // glue between the decode, the two sub-blocks and the sequencer
  logic unlock_active, unlock_success;
  logic [WORD_W-1:0] buf_rd_data;
  logic ctrl_wr, buf_commit, start_ew, start_rd, start_unlock;
  logic [ADDR_W-1:0] page_base;

  // one-hot address decode for writes
  function automatic logic hit(input logic [7:0] off);
    return reg_wr && (reg_addr == off);
  endfunction

  // strobe decode; hit() reads reg_wr and reg_addr directly, and an assign
  // would only wake up when its constant argument changed, so always_comb it is
  always_comb begin
    ctrl_wr = hit(REG_CTRL);
    buf_commit = hit(REG_D0_HI);
  end
  // write trigger honoured only when unlocked and in erase or write mode
  assign start_ew = ctrl_wr && reg_wdata[BIT_WRITE] && (state_q == ST_IDLE) &&
                    enabled_q &&
                    ((reg_wdata[MODE_HI:MODE_LO] == MODE_ERASE) ||
                     (reg_wdata[MODE_HI:MODE_LO] == MODE_WRITE));
  // read needs no unlock, only read mode and the enable bit; write trigger wins a tie
  assign start_rd = ctrl_wr && reg_wdata[BIT_READ] && !reg_wdata[BIT_WRITE] &&
                    (state_q == ST_IDLE) && reg_wdata[BIT_READ_EN] &&
                    (reg_wdata[MODE_HI:MODE_LO] == MODE_READ);
  assign start_unlock = ctrl_wr && reg_wdata[BIT_UNLOCK] && (state_q == ST_IDLE) &&
                        (reg_wdata[MODE_HI:MODE_LO] == MODE_UNLOCK);
  // page frame comes from address bits 12:5 only
  assign page_base = {addr_hi_q, addr_lo_q[7:PTR_W], {PTR_W{1'b0}}};

  // the high byte write commits {high, low} at the load pointer
  page_write_buffer u_buf (
    .clk(clk),
    .rst(rst),
    .wr_en(buf_commit),
    .wr_idx(ptr_q),
    .wr_data({reg_wdata, d0_lo_q}),
    .clr(clear_q),
    .rd_idx(walk_q),
    .rd_data(buf_rd_data)
  );

  // key pairs 1 to 3 feed the window checker as they stand
  unlock_checker u_unlock (
    .clk(clk),
    .rst(rst),
    .start(start_unlock),
    .key_l1(d1_lo_q),
    .key_l2(d2_lo_q),
    .key_l3(d3_lo_q),
    .key_h1(d1_hi_q),
    .key_h2(d2_hi_q),
    .key_h3(d3_hi_q),
    .active(unlock_active),
    .success(unlock_success)
  );

  // mode field and read enable bit; software writes them only while idle
  // a busy write leaves them alone so the running job sees a fixed mode
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_q <= MODE_RESET;
      read_en_q <= 1'b0;
    end else if (ctrl_wr && state_q == ST_IDLE) begin
      mode_q <= reg_wdata[MODE_HI:MODE_LO];
      read_en_q <= reg_wdata[BIT_READ_EN];
    end
  end

  // enabled flag: hardware sets, software may only clear; set wins a same-cycle clear
  // a clear during a running job lands at once; the job itself still finishes
  // a trigger in the same write as the clear still sees the old flag
  always_ff @(posedge clk) begin
    if (rst) begin
      enabled_q <= 1'b0;
    end else if (unlock_success) begin
      enabled_q <= 1'b1;
    end else if (ctrl_wr && !reg_wdata[BIT_ENABLED]) begin
      enabled_q <= 1'b0;
    end
  end

  // buffer clear bit is live for one cycle, the clear itself takes one cycle
  // a repeat clear write in the very next cycle folds into the first one
  always_ff @(posedge clk) begin
    if (rst) begin
      clear_q <= 1'b0;
    end else begin
      clear_q <= hit(REG_CLEAR) && reg_wdata[BIT_CLEAR] && !clear_q;
    end
  end

  // address registers; the high one keeps only bits that exist in a word address
  // only the low one moves the load pointer, see below
  always_ff @(posedge clk) begin
    if (rst) begin
      addr_lo_q <= '0;
      addr_hi_q <= '0;
    end else begin
      if (hit(REG_ADDR_LO)) begin
        addr_lo_q <= reg_wdata;
      end
      if (hit(REG_ADDR_HI)) begin
        addr_hi_q <= reg_wdata[4:0] & ADDR_HI_MASK;
      end
    end
  end

  // buffer pointer: loaded from the in-page address, saturates at the last word
  // extra words overwrite the last slot rather than spill into the next page
  always_ff @(posedge clk) begin
    if (rst) begin
      ptr_q <= '0;
    end else if (hit(REG_ADDR_LO)) begin
      ptr_q <= reg_wdata[PTR_W-1:0];
    end else if (buf_commit && ptr_q != PTR_LAST) begin
      ptr_q <= ptr_q + 1'b1;
    end
  end

  // data pair 0: software loads it, a finished read overwrites it
  // the flash word wins over a software write landing in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      d0_lo_q <= '0;
      d0_hi_q <= '0;
    end else if (state_q == ST_READ && cnt_q == CNT_W'(READ_CYCLES - 1)) begin
      d0_lo_q <= flash_rdata[7:0];
      d0_hi_q <= flash_rdata[15:8];
    end else begin
      if (hit(REG_D0_LO)) begin
        d0_lo_q <= reg_wdata;
      end
      if (buf_commit) begin
        d0_hi_q <= reg_wdata;
      end
    end
  end

  // key pairs, plain storage checked by the unlock window
  // they stay readable, so a key left behind is visible to software
  always_ff @(posedge clk) begin
    if (rst) begin
      d1_lo_q <= '0;
      d1_hi_q <= '0;
      d2_lo_q <= '0;
      d2_hi_q <= '0;
      d3_lo_q <= '0;
      d3_hi_q <= '0;
    end else begin
      if (hit(REG_D1_LO)) d1_lo_q <= reg_wdata;
      if (hit(REG_D1_HI)) d1_hi_q <= reg_wdata;
      if (hit(REG_D2_LO)) d2_lo_q <= reg_wdata;
      if (hit(REG_D2_HI)) d2_hi_q <= reg_wdata;
      if (hit(REG_D3_LO)) d3_lo_q <= reg_wdata;
      if (hit(REG_D3_HI)) d3_hi_q <= reg_wdata;
    end
  end

  // operation sequencer; the cycle counter runs from the trigger write
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      cnt_q <= '0;
      walk_q <= '0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          // counters rest at zero so every job times from its first busy cycle
          cnt_q <= '0;
          walk_q <= '0;
          if (start_ew) begin
            // erase is whole page, write walks every buffer word
            state_q <= (reg_wdata[MODE_HI:MODE_LO] == MODE_ERASE) ?
                       ST_ERASE : ST_PROG;
          end else if (start_rd) begin
            state_q <= ST_READ;
          end
        end
        ST_ERASE: begin
          // one erase pulse for the whole page, then the common wait
          cnt_q <= cnt_q + 1'b1;
          state_q <= ST_WAIT;
        end
        ST_PROG: begin
          // one program pulse per buffer word, walking 0 to 31
          cnt_q <= cnt_q + 1'b1;
          walk_q <= walk_q + 1'b1;
          if (walk_q == PTR_LAST) begin
            state_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          cnt_q <= cnt_q + 1'b1;
          // pulses fit inside the window, so the total stays the full time
          if (cnt_q >= CNT_W'(OP_CYCLES_P - 1)) begin
            state_q <= ST_IDLE;
          end
        end
        ST_READ: begin
          // the data pair takes the flash word in the last of these cycles
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == CNT_W'(READ_CYCLES - 1)) begin
            state_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // flash macro strobes, registered so the array sees clean pulses
  always_ff @(posedge clk) begin
    if (rst) begin
      flash_addr_q <= '0;
      flash_wdata_q <= '0;
      flash_prog_q <= 1'b0;
      flash_erase_q <= 1'b0;
      flash_rd_q <= 1'b0;
    end else begin
      flash_prog_q <= (state_q == ST_PROG);
      flash_erase_q <= (state_q == ST_ERASE);
      flash_rd_q <= start_rd;
      if (state_q == ST_PROG) begin
        // address never leaves the selected page
        flash_addr_q <= page_base | {{(ADDR_W-PTR_W){1'b0}}, walk_q};
        flash_wdata_q <= buf_rd_data;
      end else if (state_q == ST_ERASE) begin
        flash_addr_q <= page_base;
        flash_wdata_q <= '0;
      end else if (start_rd) begin
        // a read uses the full word address, not the page base
        flash_addr_q <= {addr_hi_q, addr_lo_q};
      end
    end
  end

  // register read port, data one cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        // triggers read back as live busy flags, so software can poll them
        REG_CTRL: rdata_q <= {enabled_q, mode_q, unlock_active,
                              (state_q inside {ST_ERASE, ST_PROG, ST_WAIT}),
                              read_en_q, (state_q == ST_READ)};
        REG_CLEAR: rdata_q <= {7'h00, clear_q};
        REG_ADDR_LO: rdata_q <= addr_lo_q;
        REG_ADDR_HI: rdata_q <= {3'h0, addr_hi_q};
        REG_D0_LO: rdata_q <= d0_lo_q;
        REG_D0_HI: rdata_q <= d0_hi_q;
        REG_D1_LO: rdata_q <= d1_lo_q;
        REG_D1_HI: rdata_q <= d1_hi_q;
        REG_D2_LO: rdata_q <= d2_lo_q;
        REG_D2_HI: rdata_q <= d2_hi_q;
        REG_D3_LO: rdata_q <= d3_lo_q;
        REG_D3_HI: rdata_q <= d3_hi_q;
        default: rdata_q <= 8'h00;
      endcase
    end
  end

  assign reg_rdata = rdata_q;
  // the cpu halts for every accepted erase, write or read
  assign cpu_stall = (state_q != ST_IDLE);
  // flash-side outputs come straight from their flops
  assign flash_addr = flash_addr_q;
  assign flash_wdata = flash_wdata_q;
  assign flash_prog = flash_prog_q;
  assign flash_erase = flash_erase_q;
  assign flash_rd = flash_rd_q;

endmodule
`default_nettype wire

/* File: bench/iap_checker_sva.sv */
`timescale 1ns/1ns
`default_nettype none
module iap_checker #(
  parameter int OP_CYCLES_P = flash_iap_pkg::OP_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic cpu_stall,
  input wire logic [flash_iap_pkg::ADDR_W-1:0] flash_addr,
  input wire logic flash_prog,
  input wire logic flash_erase,
  input wire logic flash_rd
);
  import flash_iap_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // length of the current stall run, judged when the stall drops
  logic [31:0] stall_len_q;
  always_ff @(posedge clk) begin
    if (rst || !cpu_stall) begin
      stall_len_q <= '0;
    end else begin
      stall_len_q <= stall_len_q + 32'h1;
    end
  end
  stall_len_a: assert property ($fell(cpu_stall) |->
    (stall_len_q == OP_CYCLES_P) || (stall_len_q == READ_CYCLES)) else $error("bad stall length");
  read_len_a: assert property ($rose(flash_rd) |->
    cpu_stall [*8] ##1 cpu_stall [*4] ##1 !cpu_stall) else $error("read stall not 12 cycles");
  stall_cause_a: assert property ($rose(cpu_stall) |->
    flash_rd or (##1 (flash_erase || flash_prog))) else $error("stall without operation");
  erase_page_a: assert property (flash_erase |->
    (flash_addr[4:0] == 5'h00) && cpu_stall ##1 !flash_erase) else $error("erase not page base");
  prog_start_a: assert property ($rose(flash_prog) |->
    (flash_addr[4:0] == 5'h00) && cpu_stall ##1 flash_prog [*7]) else $error("bad burst start");
  prog_step_a: assert property (flash_prog && $past(flash_prog) |->
    (flash_addr[4:0] == $past(flash_addr[4:0]) + 5'h01) &&
    (flash_addr[12:5] == $past(flash_addr[12:5]))) else $error("burst address step wrong");
  prog_end_a: assert property ($fell(flash_prog) |->
    $past(flash_addr[4:0]) == 5'h1F) else $error("burst not 32 words");
  read_alone_a: assert property (flash_rd |->
    !flash_prog && !flash_erase && cpu_stall ##1 !flash_rd) else $error("read pulse wrong");
  rdata_hold_a: assert property (!$past(reg_rd) |->
    $stable(reg_rdata)) else $error("read data moved without read");
endmodule
bind flash_iap_page_programmer iap_checker #(.OP_CYCLES_P(OP_CYCLES_P)) u_iap_checker (
  .clk(clk), .rst(rst), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_stall(cpu_stall),
  .flash_addr(flash_addr), .flash_prog(flash_prog), .flash_erase(flash_erase),
  .flash_rd(flash_rd));
`default_nettype wire

/* File: bench/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import flash_iap_pkg::*;
  localparam int OPC = 64; // short operation time keeps the run brief
  typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_s;
  logic clk, rst, reg_wr, reg_rd, cpu_stall, flash_prog, flash_erase, flash_rd;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
  logic [ADDR_W-1:0] flash_addr;
  logic [WORD_W-1:0] flash_wdata, flash_rdata;
  logic [WORD_W-1:0] mem [0:8191]; // flash array seen by the block
  logic [WORD_W-1:0] ex [0:33]; // expected words 13F..160
  int n_fail, checks, cyc, n;
  // offset, written value, value read back
  row_s rows [6] = '{'{REG_ADDR_LO, 8'h3C, 8'h3C}, '{REG_D1_LO, 8'h12, 8'h12},
    '{REG_D3_HI, 8'h7E, 8'h7E}, '{REG_CTRL, 8'h80, 8'h00}, '{8'h20, 8'h55, 8'h00},
    '{REG_CLEAR, 8'h01, 8'h00}};
  flash_iap_page_programmer #(.OP_CYCLES_P(OPC)) u_flash_iap_page_programmer (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_stall(cpu_stall), .flash_addr(flash_addr),
    .flash_wdata(flash_wdata), .flash_prog(flash_prog), .flash_erase(flash_erase),
    .flash_rd(flash_rd), .flash_rdata(flash_rdata));
  assign flash_rdata = mem[flash_addr];
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk; // full speed throughout
  end
  // array model: erase blanks a page to zero, a program pulse stores a word
  always @(posedge clk) begin
    if (flash_prog) mem[flash_addr] <= flash_wdata;
    if (flash_erase) for (int i = 0; i < 32; i++) mem[{flash_addr[12:5], 5'(i)}] <= 16'h0000;
  end
  // hang guard, well above the few thousand cycles needed
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    if (n_fail == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one-cycle write strobe, dropped at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // data stand in the cycle after the strobe is taken
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask
  // counts stalled cycles, bounded
  task automatic wait_idle();
    #1 n = 0;
    while (cpu_stall === 1'b1 && n < OPC + 100) begin
      @(posedge clk);
      #1 n++;
    end
  endtask
  task automatic set_keys(input logic [7:0] l1);
    wr(REG_D1_LO, l1);
    wr(REG_D2_LO, KEY_L2);
    wr(REG_D3_LO, KEY_L3);
    wr(REG_D1_HI, KEY_H1);
    wr(REG_D2_HI, KEY_H2);
    wr(REG_D3_HI, KEY_H3);
  endtask
  // erase request that must be refused: no stall, trigger reads 0
  task automatic try_blocked(input logic [7:0] c);
    wr(REG_CTRL, c);
    repeat (3) @(posedge clk);
    chk(cpu_stall, 1'b0);
    rd(REG_CTRL);
    chk(rv[2], 1'b0);
  endtask
  task automatic chk_page();
    for (int i = 0; i < 34; i++) chk(mem[13'(319 + i)], ex[i]);
  endtask
  // words outside the page keep their initial pattern
  task automatic base_ex();
    ex = '{default: 16'h0000};
    ex[0] = 16'hA13F;
    ex[33] = 16'hA160;
  endtask
  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    for (int i = 0; i < 8192; i++) mem[i] = {3'h5, 13'(i)};
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a);
      chk(rv, rows[i].e);
    end
    // read while still locked
    wr(REG_ADDR_HI, 8'h01);
    wr(REG_ADDR_LO, 8'h23);
    wr(REG_CTRL, 8'h33);
    wait_idle();
    chk(16'(n), 16'(READ_CYCLES));
    rd(REG_CTRL);
    chk(rv, 8'h32);
    rd(REG_D0_LO);
    chk(rv, 8'h23);
    rd(REG_D0_HI);
    chk(rv, 8'hA1);
    wr(REG_ADDR_LO, 8'h40);
    try_blocked(8'h94);
    // wrong key, then the right one
    set_keys(8'h01);
    wr(REG_CTRL, 8'h68);
    repeat (UNLOCK_CYCLES + 10) @(posedge clk);
    rd(REG_CTRL);
    chk(rv, 8'h60);
    set_keys(KEY_L1);
    wr(REG_CTRL, 8'h68);
    repeat (UNLOCK_CYCLES + 10) @(posedge clk);
    rd(REG_CTRL);
    chk(rv, 8'hE0);
    // page erase
    wr(REG_CTRL, 8'h94);
    wait_idle();
    chk(16'(n), 16'(OPC));
    base_ex();
    chk_page();
    rd(REG_CTRL);
    chk(rv, 8'h90);
    // six words from word 28: the pointer sticks at 31
    wr(REG_CTRL, 8'h80);
    wr(REG_CLEAR, 8'h01);
    wr(REG_ADDR_LO, 8'h5C);
    for (int k = 1; k < 7; k++) begin
      wr(REG_D0_LO, 8'(k));
      wr(REG_D0_HI, 8'hB0);
    end
    wr(REG_CTRL, 8'h84);
    wait_idle();
    chk(16'(n), 16'(OPC));
    base_ex();
    ex[29] = 16'hB001;
    ex[30] = 16'hB002;
    ex[31] = 16'hB003;
    ex[32] = 16'hB006;
    chk_page();
    // clear and rewrite the same page without erase
    wr(REG_CLEAR, 8'h01);
    wr(REG_ADDR_LO, 8'h40);
    wr(REG_D0_LO, 8'hEF);
    wr(REG_D0_HI, 8'hBE);
    wr(REG_CTRL, 8'h84);
    wait_idle();
    base_ex();
    ex[1] = 16'hBEEF;
    chk_page();
    // drop the flag first: a trigger in the clearing write still sees it set
    wr(REG_CTRL, 8'h10);
    try_blocked(8'h14);
    chk(mem[13'h140], 16'hBEEF);
    // reset in the middle of a read
    wr(REG_CTRL, 8'h33);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1 chk(cpu_stall, 1'b0);
    rd(REG_CTRL);
    chk(rv, 8'h00);
    rd(REG_D0_LO);
    chk(rv, 8'h00);
    end_of_test();
  end
endmodule
`default_nettype wire
